//--- verif/testbench.sv
// self-checking bench for the tdm stream timing front end
`timescale 1ns/1ns
`include "tsf_params.svh"
module testbench;
  logic         mclk = 1'b0;
  logic         nrst = 1'b0;
  logic         wps = 1'b0;
  logic         eval_r = 1'b0;
  logic         rx_ready = 1'b1;
  logic         tx_valid = 1'b0;
  logic         gci = 1'b0;
  logic         skip = 1'b0;
  logic [1:0]   rate = 2'h0;
  logic [7:0]   nch = 8'h20;
  logic [63:0]  tx_data = 64'h0;
  logic [7:0]   tx_en = 8'h0;
  logic         sclk, aux, fs, rx_valid, tx_ready, locked, gci_f, rbad, ovr, off_v;
  logic [15:0]  strm;
  logic [7:0]   so, oe;
  logic [6:0]   rx_chan;
  logic [127:0] rx_data;
  logic [10:0]  offs;
  int           num_errors = 0;
  int           checked = 0;

  always #4 mclk = ~mclk;

  tsf_peer peer_u (.mclk(mclk), .nrst(nrst), .nch(nch), .gci(gci), .skip(skip),
    .ser_clk(sclk), .aux_clk(aux), .fsync(fs), .strm(strm));

  // ce tied high: freezing is not exercised here
  tsf_front dut_u (.mclk(mclk), .nrst(nrst), .ce(1'b1), .ser_clk(sclk),
    .serial_in_streams(strm), .frame_sync_in(fs),
    .frame_eval_or_aux_clock(wps ? aux : eval_r), .wide_pulse_select(wps),
    .rate_field(rate), .serial_out_streams_upper(so), .serial_out_oe(oe),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_chan(rx_chan), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_en(tx_en),
    .frame_locked(locked), .gci_format(gci_f), .rate_bad(rbad), .rx_overrun(ovr),
    .frame_offset(offs), .offset_valid(off_v));

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic logic [127:0] exp_word(input logic [6:0] c);
    for (int k = 0; k < 16; k++)
      exp_word[8*k +: 8] = {c[3:0], 4'(k)};
  endfunction

  // hold reset past the minimum width, since shorter pulses are not honoured
  task automatic do_reset(input logic [1:0] r, input logic g, input logic w);
    @(negedge mclk);
    nrst = 1'b0;
    rate = r;
    nch = 8'h20 << r;
    gci = g;
    wps = w;
    repeat (`TSF_RST_MIN_CYC) @(negedge mclk);
    check({oe, so, rx_valid, locked, tx_ready, off_v}, 0, "reset state");
    nrst = 1'b1;
  endtask

  task automatic wait_lock;
    int n = 0;
    while (locked !== 1'b1 && n < 30000)
    begin
      @(negedge mclk);
      n++;
    end
    check(locked, 1'b1, "no frame lock");
  endtask

  // rx_ready normally high, so each word shows for one cycle
  task automatic get_word(output logic [6:0] ch);
    int n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (rx_valid !== 1'b1 && n < 200);
    ch = rx_chan;
    check(rx_data, exp_word(ch), "word data");
  endtask

  task automatic test_frames;
    logic [6:0] c;
    logic [6:0] p;
    for (int i = 0; i < 3; i++)
    begin
      do_reset(2'(i), i == 1, i == 2);
      wait_lock;
      if (i < 2)
        check(gci_f, gci, "format flag");
      check(rbad, 1'b0, "rate flag");
      get_word(p);
      repeat (nch + 1)
      begin
        get_word(c);
        check(c, (p + 7'h1) & 7'(nch - 1), "channel order");
        p = c;
      end
    end
    $display("test frames done");
  endtask

  task automatic test_eval;
    check(off_v, 1'b0, "offset before eval");
    eval_r = 1'b1;
    repeat (8) @(negedge mclk);
    eval_r = 1'b0;
    check({off_v, offs < {nch, 4'h0}}, 2'b11, "offset capture");
    $display("test eval done");
  endtask

  task automatic test_tx;
    logic [6:0] c;
    int         pulses;
    logic       bad;
    tx_data = {40'hAAAAAAAAAA, 8'h00, 8'h00, 8'hFF, 8'hFF};
    tx_en = 8'h0F;
    for (int v = 1; v >= 0; v--)
    begin
      tx_valid = v[0];
      // the first boundary may predate the new byte, so skip past it
      repeat (3) get_word(c);
      pulses = 0;
      bad = 1'b0;
      // tx_ready only stands from a serial rise to the next mclk edge
      repeat (64)
      begin
        @(posedge mclk);
        pulses += int'(tx_ready === 1'b1);
        bad |= (oe !== (v ? 8'h0F : 8'h00)) || (v && so[3:0] !== 4'h3);
      end
      @(negedge mclk);
      check(bad, 1'b0, "output drive");
      check(pulses, 1, "channel pulse");
    end
    $display("test transmit done");
  endtask

  // a stalled reader must keep its head word and flag the lost one
  task automatic test_overrun;
    logic [6:0] h;
    logic [6:0] c;
    rx_ready = 1'b0;
    repeat (256) @(negedge mclk);
    h = rx_chan;
    check({rx_valid, ovr}, 2'b11, "stall overrun");
    rx_ready = 1'b1;
    get_word(c);
    check(c, h + 7'h1, "second entry");
    $display("test overrun done");
  endtask

  task automatic test_reserved;
    logic bad = 1'b0;
    tx_valid = 1'b1;
    rate = 2'h3;
    repeat (8) @(negedge mclk);
    check(rbad, 1'b1, "reserved rate flag");
    repeat (128)
    begin
      @(negedge mclk);
      bad |= oe !== 8'h00;
    end
    check(bad, 1'b0, "reserved rate drive");
    $display("test reserved done");
  endtask

  task automatic test_loss;
    int n = 0;
    check(oe, 8'h0F, "drive before loss");
    skip = 1'b1;
    while (locked !== 1'b0 && n < 20000)
    begin
      @(negedge mclk);
      n++;
    end
    repeat (8) @(negedge mclk);
    check({locked, oe}, 0, "lock lost");
    skip = 1'b0;
    $display("test loss done");
  endtask

  initial
  begin
    test_frames;
    do_reset(2'h0, 1'b0, 1'b0);
    wait_lock;
    test_eval;
    test_tx;
    test_overrun;
    test_reserved;
    do_reset(2'h0, 1'b0, 1'b0); // mid-run reset
    wait_lock;
    tx_valid = 1'b1;
    repeat (128) @(negedge mclk);
    test_loss;
    end_of_test;
  end

  // watchdog: well past the expected run of about 30k cycles
  initial
  begin
    #600000;
    num_errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    end_of_test;
  end
endmodule

//--- verif/tsf_peer.sv
// far-side tdm peer model: serial clock, frame pulse, input stream pattern
`timescale 1ns/1ns
module tsf_peer
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // bench controls
  input  wire logic [7:0] nch,
  input  wire logic       gci,
  input  wire logic       skip,
  // serial side
  output logic            ser_clk,
  output logic            aux_clk,
  output logic            fsync,
  output logic [15:0]     strm
);
  logic [1:0]  div_r;
  logic [10:0] rise_r;

  // serial clock is mclk/4, two of its periods per bit
  always @(negedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r  <= 2'h0;
      rise_r <= 11'h7FF;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h1)
        rise_r <= (rise_r + 11'h1 >= {nch, 4'h0}) ? 11'h0 : rise_r + 11'h1;
    end
  end

  assign ser_clk = div_r[1];
  // aux clock runs with the serial clock so wide pulses land on a rise
  assign aux_clk = div_r[1];
  // idle level names the format, pulse marks rise 0 unless the bench drops it
  assign fsync = !gci ^ (rise_r == 11'h0 && !skip);

  // stream k in channel c carries {c[3:0], k[3:0]}, msb first
  always_comb
    for (int k = 0; k < 16; k++)
      strm[k] = 1'((8'(k) | {rise_r[7:4], 4'h0}) >> (3'h7 - rise_r[3:1]));
endmodule

//--- verilog/tsf_buf_if.sv
// valid/ready carrier between the front end and its receive buffer
`timescale 1ns/1ns
interface tsf_buf_if #(parameter int W = 135);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport store (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user  (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

//--- verilog/tsf_front.sv
// serial tdm stream timing front end: framing, counters, stream shifting
// Functional notes
// - sixteen inputs at rate-field-selected common rate
// - outputs same rate, three-state capable
// - serial clock shifts every input and output
// - up to 128 channels per frame
// - narrow mode auto-detects tdm or gci pulse
// - wide mode: frame pulse active low
// - reset clears counters, outputs high impedance
`timescale 1ns/1ns
`include "tsf_params.svh"
module tsf_front
  import tsf_pkg::*;
#(
  parameter int N_IN  = `TSF_N_IN,
  parameter int N_OUT = `TSF_N_OUT
)
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  // serial side
  input  wire logic                 ser_clk,
  input  wire logic [N_IN-1:0]      serial_in_streams,
  input  wire logic                 frame_sync_in,
  input  wire logic                 frame_eval_or_aux_clock,
  input  wire logic                 wide_pulse_select,
  input  wire logic [1:0]           rate_field,
  output logic      [N_OUT-1:0]     serial_out_streams_upper,
  output logic      [N_OUT-1:0]     serial_out_oe,
  // received channel words
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic      [6:0]           rx_chan,
  output logic      [8*N_IN-1:0]    rx_data,
  // transmit channel bytes
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [8*N_OUT-1:0]   tx_data,
  input  wire logic [N_OUT-1:0]     tx_en,
  // status
  output logic                      frame_locked,
  output logic                      gci_format,
  output logic                      rate_bad,
  output logic                      rx_overrun,
  output logic      [10:0]          frame_offset,
  output logic                      offset_valid
);
  localparam int WW = $bits(tsf_word_t);

  if (N_IN != 16 || N_OUT < 1 || N_OUT > 16) begin : g_chk
    $error("tsf_front: sixteen inputs and one to sixteen outputs supported");
  end

  // last channel index of a frame for a rate code
  function automatic logic [6:0] last_chan(input logic [1:0] rate);
    case (rate)
      `TSF_RATE_4M: last_chan = (`TSF_BASE_LAST << 1) | 7'h01;
      `TSF_RATE_8M: last_chan = (`TSF_BASE_LAST << 2) | 7'h03;
      default:      last_chan = `TSF_BASE_LAST;
    endcase
  endfunction

  tsf_state_t            state_r;
  logic                  sclk_d_r;
  logic                  sclk_rise;
  logic                  half_r;
  logic [2:0]            bit_r;
  logic [6:0]            chan_r;
  logic                  eof_r;
  logic                  fs_d_r;
  logic [3:0]            idle_cnt_r;
  logic                  idle_ok_r;
  logic                  aux_d_r;
  logic                  wfs_d_r;
  logic                  frame_start;
  logic                  run;
  logic                  sample;
  logic                  chan_end;
  logic [7:0]            sh_r [N_IN];
  logic [7:0]            osh_r [N_OUT];
  logic                  eval_d_r;
  tsf_word_t             word_r;
  logic                  word_v_r;
  tsf_buf_if #(.W(WW))   rxb ();

  // serial clock arrives synchronous to mclk, so a plain edge compare suffices
  assign sclk_rise = ce && ser_clk && !sclk_d_r;
  assign rate_bad  = (rate_field == `TSF_RATE_RSV);
  assign run       = sclk_rise && !rate_bad;
  assign sample    = run && half_r;
  assign chan_end  = sample && (bit_r == `TSF_BIT_LAST);

  // narrow pulse: any departure from a settled idle level; wide: low at aux edge
  always_comb
  begin
    if (wide_pulse_select)
      frame_start = run && frame_eval_or_aux_clock && !aux_d_r
                    && !frame_sync_in && wfs_d_r;
    else
      frame_start = run && idle_ok_r && (frame_sync_in != fs_d_r);
  end

  // edge history of the serial and auxiliary clocks
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d_r <= 1'b0;
      aux_d_r  <= 1'b0;
    end
    else if (ce)
    begin
      sclk_d_r <= ser_clk;
      aux_d_r  <= frame_eval_or_aux_clock;
    end
  end

  // idle level tracking for format detection, in serial clock periods
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      fs_d_r     <= 1'b1;
      idle_cnt_r <= 4'h0;
      idle_ok_r  <= 1'b0;
      gci_format <= 1'b0;
    end
    else if (run)
    begin
      fs_d_r <= frame_sync_in;
      if (frame_sync_in != fs_d_r)
      begin
        idle_cnt_r <= 4'h0;
        idle_ok_r  <= 1'b0;
        if (frame_start)
          gci_format <= !fs_d_r;
      end
      else if (idle_cnt_r == `TSF_IDLE_MAX)
        idle_ok_r <= 1'b1;
      else
        idle_cnt_r <= idle_cnt_r + 4'h1;
    end
  end

  // wide pulse level seen at each auxiliary clock edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      wfs_d_r <= 1'b1;
    else if (ce && frame_eval_or_aux_clock && !aux_d_r)
      wfs_d_r <= frame_sync_in;
  end

  // half-bit, bit and channel counters; frame pulse restarts them
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      half_r <= 1'b0;
      bit_r  <= 3'h0;
      chan_r <= 7'h0;
      eof_r  <= 1'b0;
    end
    else if (frame_start)
    begin
      half_r <= 1'b1;
      bit_r  <= 3'h0;
      chan_r <= 7'h0;
      eof_r  <= 1'b0;
    end
    else if (run)
    begin
      half_r <= !half_r;
      if (half_r)
      begin
        bit_r <= bit_r + 3'h1;
        eof_r <= chan_end && (chan_r == last_chan(rate_field));
        if (chan_end)
          chan_r <= (chan_r >= last_chan(rate_field)) ? 7'h0 : chan_r + 7'h1;
      end
      else
        eof_r <= 1'b0;
    end
  end

  // lock follows frame pulses; a missing pulse at frame end drops it
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      state_r <= TSF_HUNT;
    else if (ce)
    begin
      case (state_r)
        TSF_HUNT: if (frame_start) state_r <= TSF_LOCK;
        TSF_LOCK: if (rate_bad || (run && eof_r && !frame_start)) state_r <= TSF_HUNT;
        default:  state_r <= TSF_HUNT;
      endcase
    end
  end
  assign frame_locked = (state_r == TSF_LOCK);

  // input shifters, msb first, one sample per bit
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < N_IN; k++)
        sh_r[k] <= 8'h00;
    end
    else if (sample)
    begin
      for (int k = 0; k < N_IN; k++)
        sh_r[k] <= {sh_r[k][6:0], serial_in_streams[k]};
    end
  end

  // channel word toward the buffer; overwritten only if the buffer stays full
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      word_r     <= '0;
      word_v_r   <= 1'b0;
      rx_overrun <= 1'b0;
    end
    else if (ce)
    begin
      if (chan_end && frame_locked)
      begin
        word_r.chan <= chan_r;
        for (int k = 0; k < N_IN; k++)
          word_r.data[8*k +: 8] <= {sh_r[k][6:0], serial_in_streams[k]};
        word_v_r <= 1'b1;
        if (word_v_r && !rxb.in_ready)
          rx_overrun <= 1'b1;
      end
      else if (rxb.in_ready)
        word_v_r <= 1'b0;
    end
  end

  assign rxb.in_data   = word_r;
  assign rxb.in_valid  = word_v_r;
  assign rxb.out_ready = rx_ready;
  assign rx_valid      = rxb.out_valid;
  assign rx_chan       = rxb.out_data[WW-1 -: 7];
  assign rx_data       = rxb.out_data[8*N_IN-1:0];

  tsf_skid #(.W(WW)) u_skid (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .bus  (rxb)
  );

  // next channel byte is taken at each channel boundary while frame_locked
  assign tx_ready = chan_end && frame_locked;

  // output shifters and three-state enables; released whenever unlocked
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < N_OUT; k++)
        osh_r[k] <= 8'h00;
      serial_out_streams_upper <= '0;
      serial_out_oe            <= '0;
    end
    else if (ce)
    begin
      if (!frame_locked || rate_bad)
        serial_out_oe <= '0;
      else if (tx_ready)
      begin
        for (int k = 0; k < N_OUT; k++)
          osh_r[k] <= tx_data[8*k +: 8];
        serial_out_oe <= tx_valid ? tx_en : '0;
      end
      else if (run && !half_r)
      begin
        for (int k = 0; k < N_OUT; k++)
        begin
          serial_out_streams_upper[k] <= osh_r[k][7];
          osh_r[k]                    <= {osh_r[k][6:0], 1'b0};
        end
      end
    end
  end

  // narrow mode: position of the evaluation pulse in half-bit units
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      eval_d_r     <= 1'b0;
      frame_offset <= 11'h000;
      offset_valid <= 1'b0;
    end
    else if (run && !wide_pulse_select)
    begin
      eval_d_r <= frame_eval_or_aux_clock;
      if (frame_eval_or_aux_clock && !eval_d_r && frame_locked)
      begin
        frame_offset <= {chan_r, bit_r, half_r};
        offset_valid <= 1'b1;
      end
    end
  end

  property p_restart;
    @(posedge mclk) disable iff (!nrst)
      frame_start |=> (chan_r == 7'h0 && bit_r == 3'h0 && half_r);
  endproperty
  a_restart: assert property (p_restart) else $error("counters not restarted");

  property p_chan_max;
    @(posedge mclk) disable iff (!nrst)
      (frame_locked && !rate_bad) |-> chan_r <= last_chan(rate_field);
  endproperty
  a_chan_max: assert property (p_chan_max) else $error("channel past frame end");

  property p_hiz_unlocked;
    @(posedge mclk) disable iff (!nrst)
      (ce && !frame_locked) |=> (serial_out_oe == '0);
  endproperty
  a_hiz_unlocked: assert property (p_hiz_unlocked) else $error("driving while unlocked");

  property p_rsv_halt;
    @(posedge mclk) disable iff (!nrst)
      rate_bad |=> ($stable(bit_r) && $stable(chan_r));
  endproperty
  a_rsv_halt: assert property (p_rsv_halt) else $error("counting on reserved rate");

  property p_wide_low;
    @(posedge mclk) disable iff (!nrst)
      (frame_start && wide_pulse_select) |-> (!frame_sync_in && !aux_d_r);
  endproperty
  a_wide_low: assert property (p_wide_low) else $error("wide pulse not low");

  property p_fmt;
    @(posedge mclk) disable iff (!nrst)
      (frame_start && !wide_pulse_select) |=> (gci_format == $past(frame_sync_in));
  endproperty
  a_fmt: assert property (p_fmt) else $error("format flag mismatch");

  property p_tx_slot;
    @(posedge mclk) disable iff (!nrst)
      (tx_ready && !frame_start)
        |=> (bit_r == 3'h0 && !half_r
             && serial_out_oe == ($past(tx_valid) ? $past(tx_en) : '0));
  endproperty
  a_tx_slot: assert property (p_tx_slot) else $error("tx byte off boundary");

  property p_offset;
    @(posedge mclk) disable iff (!nrst)
      (run && !wide_pulse_select && frame_locked && frame_eval_or_aux_clock && !eval_d_r)
        |=> (offset_valid && frame_offset == $past({chan_r, bit_r, half_r}));
  endproperty
  a_offset: assert property (p_offset) else $error("offset not captured");
endmodule

//--- verilog/tsf_params.svh
// constants for the tdm stream timing front end
`ifndef TSF_PARAMS_SVH
`define TSF_PARAMS_SVH
`define TSF_CLK_PERIOD_NS 8
`define TSF_RST_MIN_NS    100
`define TSF_RST_MIN_CYC   ((`TSF_RST_MIN_NS + `TSF_CLK_PERIOD_NS - 1) / `TSF_CLK_PERIOD_NS)
`define TSF_RATE_2M       2'h0
`define TSF_RATE_4M       2'h1
`define TSF_RATE_8M       2'h2
`define TSF_RATE_RSV      2'h3
`define TSF_BASE_LAST     7'h1F
`define TSF_N_IN          16
`define TSF_N_OUT         8
`define TSF_IDLE_MAX      4'hF
`define TSF_BIT_LAST      3'h7
`endif

//--- verilog/tsf_pkg.sv
// types shared by the tdm stream timing front end
package tsf_pkg;
  typedef enum logic [1:0] {TSF_HUNT = 2'b01, TSF_LOCK = 2'b10} tsf_state_t;
  typedef struct packed
  {
    logic [6:0]   chan;
    logic [127:0] data;
  } tsf_word_t;
endpackage

//--- verilog/tsf_skid.sv
// two-entry valid/ready buffer for received channel words
`timescale 1ns/1ns
module tsf_skid
  import tsf_pkg::*;
#(
  parameter int W = 135
)
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  // buffered path
  tsf_buf_if.store  bus
);
  logic [W-1:0] d0_r;
  logic [W-1:0] d1_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  if (W < 1) begin : g_chk
    $error("tsf_skid: width must be positive");
  end

  // full drops in_ready; the front end cannot stall, so it overwrites its pending word and sets rx_overrun
  assign bus.in_ready  = (cnt_r != 2'h2);
  assign bus.out_valid = (cnt_r != 2'h0);
  assign bus.out_data  = d0_r;
  assign push          = ce && bus.in_valid && bus.in_ready;
  assign pop           = ce && bus.out_valid && bus.out_ready;

  // occupancy
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= 2'h0;
    else if (push && !pop)
      cnt_r <= cnt_r + 2'h1;
    else if (pop && !push)
      cnt_r <= cnt_r - 2'h1;
  end

  // head entry
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      d0_r <= '0;
    else if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)))
      d0_r <= bus.in_data;
    else if (pop && cnt_r == 2'h2)
      d0_r <= d1_r;
  end

  // second entry
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      d1_r <= '0;
    else if (push && cnt_r == 2'h1 && !pop)
      d1_r <= bus.in_data;
  end

  property p_skid_bound;
    @(posedge mclk) disable iff (!nrst) cnt_r != 2'h3;
  endproperty
  a_skid_bound: assert property (p_skid_bound) else $error("buffer count overflow");

  property p_skid_keep;
    @(posedge mclk) disable iff (!nrst)
      (bus.out_valid && !bus.out_ready) |=> (bus.out_valid && $stable(bus.out_data));
  endproperty
  a_skid_keep: assert property (p_skid_keep) else $error("stalled head word changed");
endmodule
